//--- src/ocp_unit.sv
// Design: output compare pulse unit with two time bases and an Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - single-pulse code drives pin low, arms pulse
// - select bit picks which timer feeds compares
// - primary match drives pin high
// - single mode: secondary match drops pin, stops
// - secondary match sets flag; irq if enabled
// - rewriting single code rearms without timer clear
// - continuous code forces low, pulses every match
// - continuous: secondary match gives falling edge
// - continuous: each secondary match ending a pulse sets flag
// - count equal period reloads zero, keeps counting
module ocp_unit (
    input  wire logic                   mclk,       // 20 MHz clock
    input  wire logic                   rst_b,      // Async reset, active low
    input  wire ocp_pkg::ocp_avreq_type av_req,     // Avalon request group
    output logic [31:0]                 av_readdata, // Read data, registered
    output logic                        av_waitrequest, // Stall
    output logic                        compare_output_pin, // Pulse output
    output logic                        irq         // Level interrupt
);
    import ocp_pkg::*;

    // ==========================================================
    // Module state, one struct
    typedef struct packed {
        logic [15:0]   control;
        logic [15:0]   primary;
        logic [15:0]   secondary;
        ocp_tb_type    tb0;
        ocp_tb_type    tb1;
        logic          inc0;      // Timer 0 advanced last cycle
        logic          inc1;
        ocp_state_type st;
        logic          pin;
        logic          status;
        logic          mask;
        logic          ack;       // Read/write answered this cycle
        logic [31:0]   rdata;
    } ocp_state_all_type;

    ocp_state_all_type cur;
    ocp_state_all_type nxt;
    logic              rst_meta;
    logic              rst_sync_b;

    // ==========================================================
    // Reset release through two flops
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta   <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_b <= rst_meta;
        end
    end

    // Merge a 32-bit write into a 16-bit register by byte lanes
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        logic [15:0] r;
        r = old;
        if (be[0]) r[7:0]  = wd[7:0];
        if (be[1]) r[15:8] = wd[15:8];
        return r;
    endfunction : merge16

    // Timer step: reload to zero at the period, else count up
    function automatic logic [15:0] step(input ocp_tb_type t);
        return (t.count == t.period) ? RESET_WORD : t.count + 16'h0001;
    endfunction : step

    // ==========================================================
    // Next-state logic
    logic        wr;
    logic        rd;
    logic        mode_wr;
    logic [15:0] sel_cnt;
    logic        sel_inc;
    logic        pmatch;
    logic        smatch;
    logic [2:0]  mode;

    always_comb begin
        nxt     = cur;
        wr      = av_req.write && !cur.ack;
        rd      = av_req.read && !cur.ack;
        nxt.ack = wr || rd;
        mode_wr = 1'b0;

        // Time bases run freely whenever their run bit is set
        nxt.inc0 = cur.tb0.run;
        nxt.inc1 = cur.tb1.run;
        if (cur.tb0.run) nxt.tb0.count = step(cur.tb0);
        if (cur.tb1.run) nxt.tb1.count = step(cur.tb1);

        // Compare against the chosen time base; only on a fresh count
        // value, so a stopped timer cannot retrigger the same match
        sel_cnt = cur.control[TBSEL_BIT] ? cur.tb1.count : cur.tb0.count;
        sel_inc = cur.control[TBSEL_BIT] ? cur.inc1 : cur.inc0;
        pmatch  = sel_inc && (sel_cnt == cur.primary);
        smatch  = sel_inc && (sel_cnt == cur.secondary);
        mode    = cur.control[MODE_LSB +: 3];

        // Pulse sequencer
        case (cur.st)
            OCP_ST_WAIT: begin
                if (pmatch) begin
                    nxt.st  = OCP_ST_HIGH;
                    nxt.pin = 1'b1;
                end
            end
            OCP_ST_HIGH: begin
                if (smatch) begin
                    nxt.pin    = 1'b0;
                    nxt.status = 1'b1;
                    nxt.st     = (mode == OCP_MODE_CONT) ? OCP_ST_WAIT
                                                         : OCP_ST_DONE;
                end
            end
            OCP_ST_IDLE: nxt.st = OCP_ST_IDLE;
            OCP_ST_DONE: nxt.st = OCP_ST_DONE;
            default:     nxt.st = OCP_ST_IDLE;
        endcase

        // Register writes
        if (wr) begin
            case (av_req.address)
                ADDR_CONTROL: begin
                    nxt.control = merge16(cur.control, av_req.writedata, av_req.byteenable);
                    mode_wr     = av_req.byteenable[0];
                end
                ADDR_PRIMARY:   nxt.primary   = merge16(cur.primary, av_req.writedata,
                                                        av_req.byteenable);
                ADDR_SECONDARY: nxt.secondary = merge16(cur.secondary, av_req.writedata,
                                                        av_req.byteenable);
                ADDR_TB0_CTRL:  if (av_req.byteenable[1])
                                    nxt.tb0.run = av_req.writedata[RUN_BIT];
                ADDR_TB0_PER:   nxt.tb0.period = merge16(cur.tb0.period, av_req.writedata,
                                                         av_req.byteenable);
                ADDR_TB0_CNT:   nxt.tb0.count  = merge16(cur.tb0.count, av_req.writedata,
                                                         av_req.byteenable);
                ADDR_TB1_CTRL:  if (av_req.byteenable[1])
                                    nxt.tb1.run = av_req.writedata[RUN_BIT];
                ADDR_TB1_PER:   nxt.tb1.period = merge16(cur.tb1.period, av_req.writedata,
                                                         av_req.byteenable);
                ADDR_TB1_CNT:   nxt.tb1.count  = merge16(cur.tb1.count, av_req.writedata,
                                                         av_req.byteenable);
                ADDR_STATUS:    if (av_req.byteenable[0] && av_req.writedata[EVT_BIT]
                                    && !(cur.st == OCP_ST_HIGH && smatch))
                                    nxt.status = 1'b0;  // Set wins over clear
                ADDR_MASK:      if (av_req.byteenable[0])
                                    nxt.mask = av_req.writedata[EVT_BIT];
                default: ;
            endcase
        end

        // Any write of a mode code restarts the sequencer with the pin low;
        // the timers are left alone so a pulse can be rearmed on the fly
        if (mode_wr) begin
            nxt.pin = 1'b0;
            case (av_req.writedata[MODE_LSB +: 3])
                OCP_MODE_SINGLE: nxt.st = OCP_ST_WAIT;
                OCP_MODE_CONT:   nxt.st = OCP_ST_WAIT;
                default:         nxt.st = OCP_ST_IDLE;
            endcase
        end

        // Read data, registered; unmapped reads return zero
        nxt.rdata = UNMAPPED_RD;
        if (rd) begin
            case (av_req.address)
                ADDR_CONTROL:   nxt.rdata = {16'h0000, cur.control};
                ADDR_PRIMARY:   nxt.rdata = {16'h0000, cur.primary};
                ADDR_SECONDARY: nxt.rdata = {16'h0000, cur.secondary};
                ADDR_TB0_CTRL:  nxt.rdata = {16'h0000, cur.tb0.run, 15'h0000};
                ADDR_TB0_PER:   nxt.rdata = {16'h0000, cur.tb0.period};
                ADDR_TB0_CNT:   nxt.rdata = {16'h0000, cur.tb0.count};
                ADDR_TB1_CTRL:  nxt.rdata = {16'h0000, cur.tb1.run, 15'h0000};
                ADDR_TB1_PER:   nxt.rdata = {16'h0000, cur.tb1.period};
                ADDR_TB1_CNT:   nxt.rdata = {16'h0000, cur.tb1.count};
                ADDR_STATUS:    nxt.rdata = {31'h0000_0000, cur.status};
                ADDR_MASK:      nxt.rdata = {31'h0000_0000, cur.mask};
                default:        nxt.rdata = UNMAPPED_RD;
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end

    // Outputs: one wait cycle per access, data and pin from flops
    assign av_waitrequest     = (av_req.read || av_req.write) && !cur.ack;
    assign av_readdata        = cur.rdata;
    assign compare_output_pin = cur.pin;
    assign irq                = cur.status && cur.mask;

    // ==========================================================
    // Assertions
    a_rise_on_primary: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        (cur.st == OCP_ST_WAIT && pmatch && !mode_wr) |=> compare_output_pin)
        else $error("pin did not rise on primary match");
    a_fall_on_secondary: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        (cur.st == OCP_ST_HIGH && smatch && !mode_wr) |=> !compare_output_pin)
        else $error("pin did not fall on secondary match");
    a_flag_on_secondary: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        (cur.st == OCP_ST_HIGH && smatch) |=> cur.status)
        else $error("flag not set on secondary match");
    a_single_stays_low: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        (cur.st == OCP_ST_DONE && !mode_wr) |=> !compare_output_pin)
        else $error("pin rose after single pulse ended");
    a_mode_write_low: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        mode_wr |=> !compare_output_pin)
        else $error("mode write did not force pin low");
    a_rearm_single: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        (mode_wr && av_req.writedata[2:0] == 3'b100) |=> cur.st == OCP_ST_WAIT)
        else $error("single code did not rearm");
    a_wrap_zero: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        (cur.tb0.run && cur.tb0.count == cur.tb0.period && !wr) |=> cur.tb0.count == 16'h0000)
        else $error("time base did not wrap to zero");
    a_irq_gate: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        (cur.st == OCP_ST_HIGH && smatch && cur.mask && !wr) |=> irq)
        else $error("enabled secondary match did not raise irq");
    a_cont_rearms: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        (cur.st == OCP_ST_HIGH && smatch && !mode_wr && mode == 3'b101)
        |=> cur.st == OCP_ST_WAIT)
        else $error("continuous mode did not rearm");
    a_select_timer: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        (cur.control[TBSEL_BIT] && cur.st == OCP_ST_WAIT && cur.inc1
         && cur.tb1.count == cur.primary && !mode_wr) |=> compare_output_pin)
        else $error("timer 1 primary match did not raise pin");
    a_wait_bounded: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        av_waitrequest |=> !av_waitrequest)
        else $error("waitrequest held too long");

    c_single_pulse: cover property (@(posedge mclk) disable iff (!rst_sync_b)
        cur.st == OCP_ST_HIGH ##[1:1000] cur.st == OCP_ST_DONE);
    c_cont_two: cover property (@(posedge mclk) disable iff (!rst_sync_b)
        (cur.st == OCP_ST_HIGH && smatch && mode == 3'b101) ##[1:1000] (cur.st == OCP_ST_HIGH));
    c_irq_high: cover property (@(posedge mclk) disable iff (!rst_sync_b) irq);

endmodule : ocp_unit

`default_nettype wire

//--- pkg/ocp_pkg.sv
// Package: register map, fields, modes and state types of the output compare pulse unit
package ocp_pkg;

    // ==========================================================
    // Register offsets (word addresses, one word each)
    localparam logic [3:0] ADDR_CONTROL   = 4'h0;  // compare_control_word
    localparam logic [3:0] ADDR_PRIMARY   = 4'h1;  // primary_compare_value
    localparam logic [3:0] ADDR_SECONDARY = 4'h2;  // secondary_compare_value
    localparam logic [3:0] ADDR_TB0_CTRL  = 4'h3;  // time_base_control_word, timer 0
    localparam logic [3:0] ADDR_TB0_PER   = 4'h4;  // time_base_period, timer 0
    localparam logic [3:0] ADDR_TB0_CNT   = 4'h5;  // time_base_count, timer 0
    localparam logic [3:0] ADDR_TB1_CTRL  = 4'h6;
    localparam logic [3:0] ADDR_TB1_PER   = 4'h7;
    localparam logic [3:0] ADDR_TB1_CNT   = 4'h8;
    localparam logic [3:0] ADDR_STATUS    = 4'h9;  // sticky event flags, write one to clear
    localparam logic [3:0] ADDR_MASK      = 4'ha;  // interrupt enables

    // ==========================================================
    // Field positions
    localparam int MODE_LSB     = 0;   // pulse_mode_select, bits 2..0
    localparam int TBSEL_BIT    = 3;   // time_base_select
    localparam int RUN_BIT      = 15;  // time_base_run
    localparam int EVT_BIT      = 0;   // compare_event_flag in status and mask

    // ==========================================================
    // Reset values
    localparam logic [15:0] RESET_WORD  = 16'h0000;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

    // Mode codes
    typedef enum logic [2:0] {
        OCP_MODE_OFF    = 3'b000,
        OCP_MODE_SINGLE = 3'b100,
        OCP_MODE_CONT   = 3'b101
    } ocp_mode_type;

    // Pulse sequencer states
    typedef enum logic [1:0] {
        OCP_ST_IDLE = 2'b00,   // Pin low, nothing armed
        OCP_ST_WAIT = 2'b01,   // Armed, waiting for primary match
        OCP_ST_HIGH = 2'b10,   // Pin high, waiting for secondary match
        OCP_ST_DONE = 2'b11    // Single pulse finished, pin held low
    } ocp_state_type;

    // Avalon-MM request carrier
    typedef struct packed {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } ocp_avreq_type;

    // Time base state
    typedef struct packed {
        logic        run;
        logic [15:0] period;
        logic [15:0] count;
    } ocp_tb_type;

endpackage : ocp_pkg

//--- tb/ocp_pin_model.sv
// Partner model: circuitry on the compare output pin that measures each pulse
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Pulse meter
module ocp_pin_model (
    input  wire logic        mclk,   // Unit clock
    input  wire logic        rst_b,  // Async reset, active low
    input  wire logic        pin,    // Compare output pin
    output logic             done,   // One cycle at each falling edge
    output logic [15:0]      width,  // High time of the last pulse, cycles
    output logic [15:0]      gap,    // Rise to rise of the last pulse, cycles
    output logic [7:0]       pulses  // Pulses seen since reset
);
    logic        last;
    logic [15:0] hi_cnt;
    logic [15:0] since_rise;

    // Only a load; it never drives back, so it cannot mask a pin fault
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            {done, last, width, gap, pulses, hi_cnt, since_rise} <= '0;
        end else begin
            done       <= 1'b0;
            last       <= pin;
            since_rise <= since_rise + 16'h0001;
            if (pin && !last) begin
                hi_cnt     <= 16'h0001;
                since_rise <= 16'h0001;
                gap        <= since_rise;
            end else if (pin) begin
                hi_cnt <= hi_cnt + 16'h0001;
            end
            if (!pin && last) begin
                done   <= 1'b1;
                width  <= hi_cnt;
                pulses <= pulses + 8'h01;
            end
        end
    end
endmodule : ocp_pin_model
`default_nettype wire

//--- tb/ocp_unit_test.sv
// Testbench: register access, single and continuous pulses of the compare unit
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Top of the bench
module ocp_unit_test;
    import ocp_pkg::*;
    logic          mclk;
    logic          rst_b;
    ocp_avreq_type av_req;
    logic [31:0]   av_readdata;
    logic          av_waitrequest;
    logic          compare_output_pin;
    logic          irq;
    logic          pm_done;
    logic [15:0]   pm_width;
    logic [15:0]   pm_gap;
    logic [7:0]    pm_pulses;
    logic [15:0]   p;
    logic [15:0]   s;
    logic [15:0]   per;
    int            fails;
    int            n_checks;
    logic [31:0]   rd_q[$];
    logic [31:0]   pw_q[$];   // Expected {gap, width}; gap 0 is not compared

    ocp_unit u_dut (.mclk(mclk), .rst_b(rst_b), .av_req(av_req), .av_readdata(av_readdata),
        .av_waitrequest(av_waitrequest), .compare_output_pin(compare_output_pin), .irq(irq));
    ocp_pin_model u_pin (.mclk(mclk), .rst_b(rst_b), .pin(compare_output_pin), .done(pm_done),
        .width(pm_width), .gap(pm_gap), .pulses(pm_pulses));

    // ==========================================================
    // Clock, comparison and closing
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    // One Avalon access; the request stands until waitrequest is sampled low
    task automatic bus(input logic rd, input logic [3:0] a, input logic [15:0] d,
                       input logic [31:0] exp);
        int n;
        av_req.address    <= a;
        av_req.read       <= rd;
        av_req.write      <= !rd;
        av_req.writedata  <= {16'h0000, d};
        av_req.byteenable <= 4'h3;
        if (rd) rd_q.push_back(exp);
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (av_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            check("waitrequest", 32'h1, 32'h0);
            print_verdict();
        end else begin
            av_req.read  <= 1'b0;
            av_req.write <= 1'b0;
            @(posedge mclk);
        end
    endtask : bus

    // Bounded wait for the pulse meter to reach a count
    task automatic wait_pulses(input logic [7:0] n);
        int k;
        k = 0;
        while (pm_pulses !== n && k < 3000) begin
            @(posedge mclk);
            k++;
        end
        if (k >= 3000) begin
            check("pulse wait", 32'h0, 32'h1);
            print_verdict();
        end
    endtask : wait_pulses

    // ==========================================================
    // Watcher: takes the oldest note whenever a result appears
    always @(posedge mclk) begin : watch
        logic [31:0] e;
        if (av_req.read === 1'b1 && av_waitrequest === 1'b0) begin
            e = (rd_q.size() > 0) ? rd_q.pop_front() : 32'hdead_0000;
            check("readdata", av_readdata, e);
        end
        if (pm_done === 1'b1) begin
            if (pw_q.size() == 0) check("unexpected pulse", 32'h1, 32'h0);
            else begin
                e = pw_q.pop_front();
                check("pulse width", {16'h0, pm_width}, {16'h0, e[15:0]});
                if (e[31:16] != 16'h0) begin
                    check("pulse gap", {16'h0, pm_gap}, {16'h0, e[31:16]});
                end
            end
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        rst_b    = 1'b0;
        av_req   = '0;
        fails    = 0;
        n_checks = 0;
        void'($urandom(32'h17e4ec8a));
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        // Reset values of every word, and one unmapped index
        for (int a = 0; a < 12; a++) bus(1'b1, a[3:0], 16'h0, (a == 11) ? UNMAPPED_RD : 32'h0);
        // Single pulse on timer 0: compares loaded before the timer runs
        bus(1'b0, ADDR_PRIMARY, 16'd5, 32'h0);
        bus(1'b0, ADDR_SECONDARY, 16'd9, 32'h0);
        bus(1'b0, ADDR_TB0_PER, 16'd20, 32'h0);
        bus(1'b0, ADDR_CONTROL, {12'h000, 1'b0, OCP_MODE_SINGLE}, 32'h0);
        check("pin after arm", {31'h0, compare_output_pin}, 32'h0);
        pw_q.push_back({16'h0, 16'd4});
        bus(1'b0, ADDR_TB0_CTRL, 16'h8000, 32'h0);
        wait_pulses(8'd1);
        repeat (70) @(posedge mclk);
        check("single pulse count", {24'h0, pm_pulses}, 32'h1);
        bus(1'b1, ADDR_STATUS, 16'h0, 32'h1);
        check("irq masked", {31'h0, irq}, 32'h0);
        bus(1'b0, ADDR_MASK, 16'h1, 32'h0);
        repeat (2) @(negedge mclk);
        check("irq enabled", {31'h0, irq}, 32'h1);
        bus(1'b0, ADDR_STATUS, 16'h1, 32'h0);
        repeat (2) @(negedge mclk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        // Rearm with the timer left running
        pw_q.push_back({16'h0, 16'd4});
        bus(1'b0, ADDR_CONTROL, {12'h000, 1'b0, OCP_MODE_SINGLE}, 32'h0);
        wait_pulses(8'd2);
        bus(1'b1, ADDR_TB0_CTRL, 16'h0, 32'h8000);
        // Continuous stream on timer 1; its period differs from timer 0
        p   = 16'd2 + 16'($urandom % 8);
        s   = p + 16'd1 + 16'($urandom % 8);
        per = 16'd24 + 16'($urandom % 8);
        bus(1'b0, ADDR_PRIMARY, p, 32'h0);
        bus(1'b0, ADDR_SECONDARY, s, 32'h0);
        bus(1'b0, ADDR_TB1_PER, per, 32'h0);
        bus(1'b0, ADDR_STATUS, 16'h1, 32'h0);
        bus(1'b0, ADDR_CONTROL, {12'h000, 1'b1, OCP_MODE_CONT}, 32'h0);
        check("pin after cont", {31'h0, compare_output_pin}, 32'h0);
        pw_q.push_back({16'h0, s - p});
        repeat (2) pw_q.push_back({per + 16'd1, s - p});
        bus(1'b0, ADDR_TB1_CTRL, 16'h8000, 32'h0);
        wait_pulses(8'd3);
        bus(1'b0, ADDR_STATUS, 16'h1, 32'h0);
        bus(1'b1, ADDR_STATUS, 16'h0, 32'h0);
        wait_pulses(8'd4);
        bus(1'b1, ADDR_STATUS, 16'h0, 32'h1);
        wait_pulses(8'd5);
        // Mode off just after a fall: the stream must stop
        bus(1'b0, ADDR_CONTROL, 16'h0000, 32'h0);
        repeat (80) @(posedge mclk);
        check("pulses after off", {24'h0, pm_pulses}, 32'h5);
        print_verdict();
    end
endmodule : ocp_unit_test
`default_nettype wire
